//--- src/igv_top.sv
// interrupt gating and vectoring logic for the core
// What this block does
// [R1] four sources: external pin, timer zero overflow, port-b upper pin change, conversion done
// [R2] flags set on their events regardless of mask and global enable
// [R3] global enable is control bit 7; set permits unmasked sources, clear blocks all
// [R4] enable plus any flag-and-mask pair takes the interrupt at once
// [R5] clearing a source's own enable stops its vector, flag keeps working
// [R6] any reset clears the global enable
// [R7] return from interrupt pops the return address and sets global enable
// [R8] pin, port-b change and timer flags live in the control register
// [R9] peripheral flags and masks in two register pairs, gated by peripheral enable
// [R10] taking an interrupt clears enable, pushes return address, loads pc 0004h
// [R11] one shared vector; software polls flags to find the source
// [R12] software clears serviced flags before re-enabling, else recursion
// [R13] pin and port-change events vector within three or four cycles; here the vector loads five cycles after the pin is first sampled
// [R14] latency independent of one- or two-cycle instruction in flight
// [R15] enable cleared during acknowledge still vectors; later return sets enable
// [R16] software clears enable and reads back until seen clear
// [R17] conversion done sets its flag and clears conversion busy
// [R18] request is enable and (core pairs or peripheral-enable-gated peripheral pairs)
`timescale 1ns/100ps
`include "igv_defines.svh"

module igv_top (
  input  wire logic                   MCLK,
  input  wire logic                   RESET,
  input  wire logic                   EXT_IRQ_PIN,
  input  wire logic [`IGV_PORTB_W-1:0] PORTB_CHANGE_PINS,
  input  wire logic                   TIMER_ZERO_OVF,
  input  wire logic                   CONV_START,
  input  wire logic                   CONV_DONE,
  input  wire logic                   REG_WR,
  input  wire logic [2:0]             REG_SEL,
  input  wire logic [7:0]             REG_WDATA,
  input  wire logic                   RETURN_FROM_IRQ,
  output logic      [7:0]             IRQ_CONTROL_REG,
  output logic      [7:0]             PERIPH_FLAG_REG_A,
  output logic      [7:0]             PERIPH_FLAG_REG_B,
  output logic      [7:0]             PERIPH_MASK_REG_A,
  output logic      [7:0]             PERIPH_MASK_REG_B,
  output logic                        CONV_BUSY,
  output logic                        IRQ_REQUEST,
  output logic                        VECTOR_LOAD,
  output logic      [`IGV_PC_W-1:0]   VECTOR_PC,
  output logic                        PUSH_RETURN,
  output logic                        POP_RETURN,
  output logic                        IN_SERVICE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  igv_pkg::igv_ctrl_s   ctrl;
  igv_pkg::igv_ctrl_s   next_ctrl;
  igv_pkg::igv_state_e  state;
  igv_pkg::igv_state_e  next_state;
  logic [7:0]           next_flag_a;
  logic [7:0]           next_flag_b;
  logic [7:0]           next_mask_a;
  logic [7:0]           next_mask_b;
  logic                 next_conv_busy;
  logic                 next_request;
  logic                 next_vector;
  logic                 next_push;
  logic                 next_pop;
  logic                 next_in_service;
  logic                 ext_filt;
  logic                 ext_prev;
  logic [`IGV_PORTB_W-1:0] pb_filt;
  logic [`IGV_PORTB_W-1:0] pb_prev;
  logic                 ext_rise;
  logic                 pb_change;
  logic                 take;

  assign IRQ_CONTROL_REG = ctrl;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  igv_sync #(
    .W (1 + `IGV_PORTB_W)
  ) u_sync (
    .MCLK  (MCLK),
    .RESET (RESET),
    .PIN   ({EXT_IRQ_PIN, PORTB_CHANGE_PINS}),
    .FILT  ({ext_filt, pb_filt})
  );

  assign ext_rise  = ext_filt & ~ext_prev;   // [R1]
  assign pb_change = |(pb_filt ^ pb_prev);   // [R1]

  // ----------------------------------------------------------------
  // request evaluation, applied to the next register values
  // ----------------------------------------------------------------
  function automatic logic igv_pending(
    input igv_pkg::igv_ctrl_s c,
    input logic [7:0]         fa,
    input logic [7:0]         fb,
    input logic [7:0]         ma,
    input logic [7:0]         mb
  );
    logic core_req;
    logic per_req;
    core_req = (c.timer_flag & c.timer_enable) | (c.pin_flag & c.pin_enable)
             | (c.change_flag & c.change_enable);                           // [R5]
    per_req  = c.periph_enable & (|(fa & ma) | |(fb & mb));                 // [R9]
    igv_pending = c.global_irq_enable & (core_req | per_req);               // [R18] [R3]
  endfunction : igv_pending

  // request register mirrors the current registers, so taking it
  // adds no latency whatever the instruction length
  assign take = IRQ_REQUEST;   // [R4] [R14]

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl       = ctrl;
    next_flag_a     = PERIPH_FLAG_REG_A;
    next_flag_b     = PERIPH_FLAG_REG_B;
    next_mask_a     = PERIPH_MASK_REG_A;
    next_mask_b     = PERIPH_MASK_REG_B;
    next_conv_busy  = CONV_BUSY;
    next_state      = state;

    // software writes
    if (REG_WR && REG_SEL == `IGV_SEL_CTRL) begin
      next_ctrl = REG_WDATA;   // [R8] [R16]
    end else if (REG_WR && REG_SEL == `IGV_SEL_FLAG_A) begin
      next_flag_a = REG_WDATA & `IGV_FLAG_A_IMPL;   // [R9]
    end else if (REG_WR && REG_SEL == `IGV_SEL_FLAG_B) begin
      next_flag_b = REG_WDATA & `IGV_FLAG_B_IMPL;
    end else if (REG_WR && REG_SEL == `IGV_SEL_MASK_A) begin
      next_mask_a = REG_WDATA;
    end else if (REG_WR && REG_SEL == `IGV_SEL_MASK_B) begin
      next_mask_b = REG_WDATA;
    end

    // hardware sets after the write so an event never gets lost
    if (ext_rise) begin
      next_ctrl.pin_flag = 1'b1;   // [R2]
    end
    if (pb_change) begin
      next_ctrl.change_flag = 1'b1;   // [R2]
    end
    if (TIMER_ZERO_OVF) begin
      next_ctrl.timer_flag = 1'b1;   // [R2]
    end
    if (CONV_START) begin
      next_conv_busy = 1'b1;
    end
    if (CONV_DONE) begin
      next_flag_a[`IGV_CONV_BIT] = 1'b1;   // [R17]
      next_conv_busy             = 1'b0;   // [R17]
    end

    // acknowledge beats a software clear of the enable in the same cycle
    if (take) begin
      next_ctrl.global_irq_enable = 1'b0;   // [R10] [R15]
      next_state    = igv_pkg::ST_SERVICE;
    end
    if (RETURN_FROM_IRQ) begin
      next_ctrl.global_irq_enable = 1'b1;   // [R7] [R15]
      next_state    = igv_pkg::ST_IDLE;
    end

    next_vector     = take;              // [R10] [R11]
    next_push       = take;              // [R10]
    next_pop        = RETURN_FROM_IRQ;   // [R7]
    next_in_service = 1'b0;
    case (next_state)
      igv_pkg::ST_IDLE: begin
        next_in_service = 1'b0;
      end
      igv_pkg::ST_SERVICE: begin
        next_in_service = 1'b1;
      end
      default: begin
        next_in_service = 1'b0;
      end
    endcase

    // still-set flags retrigger as soon as enable returns
    next_request = igv_pending(next_ctrl, next_flag_a, next_flag_b, next_mask_a, next_mask_b);   // [R4] [R13]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl              <= `IGV_REG_RESET;   // [R6]
      PERIPH_FLAG_REG_A <= `IGV_REG_RESET;
      PERIPH_FLAG_REG_B <= `IGV_REG_RESET;
      PERIPH_MASK_REG_A <= `IGV_REG_RESET;
      PERIPH_MASK_REG_B <= `IGV_REG_RESET;
      CONV_BUSY         <= 1'b0;
      IRQ_REQUEST       <= 1'b0;
      VECTOR_LOAD       <= 1'b0;
      VECTOR_PC         <= `IGV_VECTOR_ADDR;
      PUSH_RETURN       <= 1'b0;
      POP_RETURN        <= 1'b0;
      IN_SERVICE        <= 1'b0;
      state             <= igv_pkg::ST_IDLE;
      ext_prev          <= 1'b0;
      pb_prev           <= '0;
    end else begin
      ctrl              <= next_ctrl;
      PERIPH_FLAG_REG_A <= next_flag_a;
      PERIPH_FLAG_REG_B <= next_flag_b;
      PERIPH_MASK_REG_A <= next_mask_a;
      PERIPH_MASK_REG_B <= next_mask_b;
      CONV_BUSY         <= next_conv_busy;
      IRQ_REQUEST       <= next_request;
      VECTOR_LOAD       <= next_vector;
      VECTOR_PC         <= `IGV_VECTOR_ADDR;   // [R10] [R11]
      PUSH_RETURN       <= next_push;
      POP_RETURN        <= next_pop;
      IN_SERVICE        <= next_in_service;
      state             <= next_state;
      ext_prev          <= ext_filt;
      pb_prev           <= pb_filt;
    end
  end

endmodule : igv_top

//--- src/igv_defines.svh
// constants for the interrupt gating and vectoring block
`ifndef IGV_DEFINES_SVH
`define IGV_DEFINES_SVH

// ----------------------------------------------------------------
// register select codes on the software write port
// ----------------------------------------------------------------
`define IGV_SEL_CTRL       3'h0
`define IGV_SEL_FLAG_A     3'h1
`define IGV_SEL_FLAG_B     3'h2
`define IGV_SEL_MASK_A     3'h3
`define IGV_SEL_MASK_B     3'h4

// ----------------------------------------------------------------
// field positions, implemented bits and reset values
// ----------------------------------------------------------------
`define IGV_CONV_BIT       0
`define IGV_FLAG_A_IMPL    8'h01
`define IGV_FLAG_B_IMPL    8'h00
`define IGV_REG_RESET      8'h00
`define IGV_PORTB_W        4

// ----------------------------------------------------------------
// shared vector
// ----------------------------------------------------------------
`define IGV_PC_W           13
`define IGV_VECTOR_ADDR    13'h0004

`endif

//--- src/igv_pkg.sv
// types for the interrupt gating and vectoring block
package igv_pkg;

  // ----------------------------------------------------------------
  // control register layout, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic global_irq_enable;
    logic periph_enable;
    logic timer_enable;
    logic pin_enable;
    logic change_enable;
    logic timer_flag;
    logic pin_flag;
    logic change_flag;
  } igv_ctrl_s;

  typedef enum logic {
    ST_IDLE,
    ST_SERVICE
  } igv_state_e;

endpackage : igv_pkg

//--- src/igv_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module igv_sync #(
  parameter int W = 1
) (
  input  wire logic         MCLK,
  input  wire logic         RESET,
  input  wire logic [W-1:0] PIN,
  output logic      [W-1:0] FILT
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_filt;

  // ----------------------------------------------------------------
  // accept a level only once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_filt = FILT;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_filt[i] = s3[i];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      FILT <= '0;
    end else begin
      s1   <= PIN;
      s2   <= s1;
      s3   <= s2;
      FILT <= next_filt;
    end
  end

endmodule : igv_sync

//--- tb/igv_core_model.sv
// core model: runs a service routine of random length, then returns
`timescale 1ns/100ps

module igv_core_model (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       vector_load,
  input  wire logic [3:0] delay,
  output logic            return_from_irq
);
  // ------------
  // sequencer
  // ------------
  logic [4:0] cnt;
  // at least three cycles so software clears its flags first
  always_ff @(posedge mclk) begin
    return_from_irq <= 1'b0;
    if (reset) cnt <= 5'h00;
    else if (vector_load) cnt <= {1'b0, delay} + 5'h03;
    else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      return_from_irq <= (cnt == 5'h01);
    end
  end
endmodule : igv_core_model

//--- tb/igv_chk_sva.sv
// checker for the interrupt gating block
`timescale 1ns/100ps
`include "igv_defines.svh"

module igv_chk (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        EXT_IRQ_PIN,
  input wire logic        TIMER_ZERO_OVF,
  input wire logic        CONV_DONE,
  input wire logic        RETURN_FROM_IRQ,
  input wire logic [7:0]  IRQ_CONTROL_REG,
  input wire logic [7:0]  PERIPH_FLAG_REG_A,
  input wire logic [7:0]  PERIPH_FLAG_REG_B,
  input wire logic [7:0]  PERIPH_MASK_REG_A,
  input wire logic [7:0]  PERIPH_MASK_REG_B,
  input wire logic        CONV_BUSY,
  input wire logic        IRQ_REQUEST,
  input wire logic        VECTOR_LOAD,
  input wire logic [12:0] VECTOR_PC,
  input wire logic        PUSH_RETURN,
  input wire logic        POP_RETURN,
  input wire logic        IN_SERVICE
);
  // ------------
  // properties
  // ------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  property p_vec; IRQ_REQUEST |=> VECTOR_LOAD && PUSH_RETURN && IN_SERVICE; endproperty
  a_vec: assert property (p_vec) else $error("no vector after request");
  property p_take; VECTOR_LOAD |-> !IRQ_CONTROL_REG[7] && VECTOR_PC == `IGV_VECTOR_ADDR; endproperty
  a_take: assert property (p_take) else $error("bad vector state");
  property p_pulse; VECTOR_LOAD |=> !VECTOR_LOAD; endproperty
  a_pulse: assert property (p_pulse) else $error("vector pulse too long");
  property p_ret; RETURN_FROM_IRQ |=> POP_RETURN && IRQ_CONTROL_REG[7] && !IN_SERVICE; endproperty
  a_ret: assert property (p_ret) else $error("bad return");
  property p_rst; disable iff (1'b0) RESET |=> IRQ_CONTROL_REG == 8'h00 && !IRQ_REQUEST; endproperty
  a_rst: assert property (p_rst) else $error("reset left enable set");
  property p_req;
    IRQ_REQUEST == (IRQ_CONTROL_REG[7] && ((|(IRQ_CONTROL_REG[5:3] & IRQ_CONTROL_REG[2:0]))
      || (IRQ_CONTROL_REG[6] && (|(PERIPH_FLAG_REG_A & PERIPH_MASK_REG_A)
      || |(PERIPH_FLAG_REG_B & PERIPH_MASK_REG_B)))));
  endproperty
  a_req: assert property (p_req) else $error("request gating wrong");
  property p_tmr; TIMER_ZERO_OVF |=> IRQ_CONTROL_REG[2]; endproperty
  a_tmr: assert property (p_tmr) else $error("timer flag not set");
  property p_conv; CONV_DONE |=> PERIPH_FLAG_REG_A[0] && !CONV_BUSY; endproperty
  a_conv: assert property (p_conv) else $error("conversion done wrong");
  property p_pin; $rose(EXT_IRQ_PIN) |-> ##[3:6] IRQ_CONTROL_REG[1]; endproperty
  a_pin: assert property (p_pin) else $error("pin flag late");
  c_conv: cover property (VECTOR_LOAD && PERIPH_FLAG_REG_A[0]);
  c_pin: cover property (VECTOR_LOAD && IRQ_CONTROL_REG[1]);
  c_ret: cover property (RETURN_FROM_IRQ);
endmodule : igv_chk

bind igv_top igv_chk u_chk (.MCLK(MCLK), .RESET(RESET), .EXT_IRQ_PIN(EXT_IRQ_PIN),
  .TIMER_ZERO_OVF(TIMER_ZERO_OVF), .CONV_DONE(CONV_DONE), .RETURN_FROM_IRQ(RETURN_FROM_IRQ),
  .IRQ_CONTROL_REG(IRQ_CONTROL_REG), .PERIPH_FLAG_REG_A(PERIPH_FLAG_REG_A),
  .PERIPH_FLAG_REG_B(PERIPH_FLAG_REG_B), .PERIPH_MASK_REG_B(PERIPH_MASK_REG_B),
  .PERIPH_MASK_REG_A(PERIPH_MASK_REG_A), .CONV_BUSY(CONV_BUSY), .IRQ_REQUEST(IRQ_REQUEST),
  .VECTOR_LOAD(VECTOR_LOAD), .VECTOR_PC(VECTOR_PC), .PUSH_RETURN(PUSH_RETURN),
  .POP_RETURN(POP_RETURN), .IN_SERVICE(IN_SERVICE));

//--- tb/testbench.sv
// self-checking bench for the interrupt gating block
`timescale 1ns/100ps
`include "igv_defines.svh"

module testbench;
  // ------------
  // stimulus
  // ------------
  logic        mclk = 1'b0, reset = 1'b1, ext = 1'b0, tov = 1'b0, cst = 1'b0, cdn = 1'b0, wr = 1'b0;
  logic        ret, busy, req, vld, push, pop, insv;
  logic [3:0]  pb = 4'h0, dly = 4'h0;
  logic [2:0]  sel = 3'h0;
  logic [7:0]  wd = 8'h00, ctrl, fa, fb, ma, mb;
  logic [12:0] pc;
  logic [7:0]  exp_q[$];
  logic [7:0]  en_t[5] = '{8'ha0, 8'h90, 8'h88, 8'hc0, 8'ha0};
  logic [7:0]  fl_t[5] = '{8'h04, 8'h02, 8'h01, 8'h00, 8'h00};
  int          err_total = 0, checks_done = 0, seed = 32'h4441, n;
  always #5 mclk = ~mclk;
  igv_top uut (.MCLK(mclk), .RESET(reset), .EXT_IRQ_PIN(ext), .PORTB_CHANGE_PINS(pb),
    .TIMER_ZERO_OVF(tov), .CONV_START(cst), .CONV_DONE(cdn), .REG_WR(wr), .REG_SEL(sel),
    .REG_WDATA(wd), .RETURN_FROM_IRQ(ret), .IRQ_CONTROL_REG(ctrl), .PERIPH_FLAG_REG_A(fa),
    .PERIPH_FLAG_REG_B(fb), .PERIPH_MASK_REG_A(ma), .PERIPH_MASK_REG_B(mb), .CONV_BUSY(busy),
    .IRQ_REQUEST(req), .VECTOR_LOAD(vld), .VECTOR_PC(pc), .PUSH_RETURN(push),
    .POP_RETURN(pop), .IN_SERVICE(insv));
  igv_core_model u_core (.mclk(mclk), .reset(reset), .vector_load(vld), .delay(dly),
    .return_from_irq(ret));
  task automatic print_verdict;
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wreg(input logic [2:0] s, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    sel <= s;
    wd <= d;
    ext <= 1'b0;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  // source 4 writes an enable clear onto the acknowledge edge
  task automatic fire(input int s);
    @(posedge mclk);
    dly <= 4'($random(seed));
    tov <= (s == 0 || s == 4);
    ext <= (s == 1);
    cst <= (s == 3);
    if (s == 2) pb <= pb ^ (4'($random(seed)) | 4'h1);
    @(posedge mclk);
    tov <= 1'b0;
    cst <= 1'b0;
    cdn <= (s == 3);
    wr <= (s == 4);
    wd <= 8'h20;
    @(posedge mclk);
    cdn <= 1'b0;
    wr <= 1'b0;
  endtask : fire
  // no open-ended wait: a hang ends the run as a failure
  task automatic wait_for(input bit vec);
    n = 0;
    while ((vec ? vld : ~insv) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 60) begin
        err_total++;
        print_verdict();
      end
    end
  endtask : wait_for
  // ------------
  // checking
  // ------------
  always @(negedge mclk) if (vld === 1'b1) begin
    if (exp_q.size() == 0) check(24'h0, 24'h1, "unexpected vector");
    else check({pc, push, ctrl}, {`IGV_VECTOR_ADDR, 1'b1, exp_q.pop_front()}, "at vector");
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check(13'(ctrl), 13'h0, "ctrl after reset");
    check(pc, `IGV_VECTOR_ADDR, "vector pc");
    wreg(`IGV_SEL_CTRL, 8'hb8);
    fire(3);
    wreg(`IGV_SEL_CTRL, 8'h80);
    fire(0);
    repeat (3) @(negedge mclk);
    check({busy, fa, 4'(ctrl)}, {1'b0, 8'h01, 4'h4}, "masked flags");
    wreg(`IGV_SEL_FLAG_A, 8'h00);
    wreg(`IGV_SEL_MASK_A, 8'h01);
    wreg(3'h5, 8'hff);
    #1 check({ma, mb, fb}, {8'h01, 8'h00, 8'h00}, "unmapped write");
    for (int s = 0; s < 5; s++) begin
      wreg(`IGV_SEL_CTRL, en_t[s]);
      exp_q.push_back((en_t[s] & 8'h7f) | fl_t[s]);
      fire(s);
      wait_for(1'b1);
      wreg(`IGV_SEL_CTRL, en_t[s] & 8'h78);
      wreg(`IGV_SEL_FLAG_A, 8'h00);
      wait_for(1'b0);
      check({pop, req, ctrl}, {1'b1, 1'b0, en_t[s] & 8'hf8}, "state after return");
    end
    // clear the enable and read it back until it is seen clear
    n = 0;
    do begin
      wreg(`IGV_SEL_CTRL, 8'h20);
      @(negedge mclk);
      n++;
    end while (ctrl[7] !== 1'b0 && n < 4);
    check(13'(ctrl), 13'h20, "ctrl after disable");
    // second reset in mid-run must clear a set enable
    wreg(`IGV_SEL_CTRL, 8'h80);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check(13'(ctrl), 13'h0, "ctrl after second reset");
    print_verdict();
  end
endmodule : testbench
